// ===== common/tocp_pkg.sv
// Package of constants for the timer compare/PWM output stage
// Functional notes
// - Compare output only when direction select is 00
// - Function 101 forces reference high, pin inverse polarity
// - Function 100 forces reference low immediately
// - Forced output still compares and flags matches
// - Match actions: keep, active, inactive, toggle
// - Match sets flag, raises enabled irq and dma
// - Compare preload off immediate, on at update
// - Update event leaves compare-mode reference unchanged
// - Codes 110 and 111 select PWM 1 and 2
// - Reload sets period, compare sets duty
// - PWM1 reference high while counter below compare
// - PWM1 compare above reload holds one, zero holds zero
// - Edge-aligned PWM only while counting upward
// - Polarity picks pin level, enable gates driving
// - Single pulse clears run bit at counter rollover
// - Compare sets delay, reload minus compare plus one length
// - Trigger input can start the counter
// - Fast enable answers trigger directly in PWM
// - Reload preload selects buffered or direct reload
package tocp_pkg;
  localparam int TOCP_CNT_W = 16;
  localparam int TOCP_ADDR_W = 4;
  // Register offsets
  localparam logic [3:0] TOCP_REG_CTRL = 4'h0;
  localparam logic [3:0] TOCP_REG_CHAN = 4'h1;
  localparam logic [3:0] TOCP_REG_EVT = 4'h2;
  localparam logic [3:0] TOCP_REG_STS = 4'h3;
  localparam logic [3:0] TOCP_REG_CNT = 4'h4;
  localparam logic [3:0] TOCP_REG_RELOAD = 4'h5;
  localparam logic [3:0] TOCP_REG_CMP = 4'h6;
  // Control register fields
  localparam int TOCP_CTRL_RUN = 0;
  localparam int TOCP_CTRL_SINGLE = 3;
  localparam int TOCP_CTRL_ARPRE = 7;
  localparam int TOCP_CTRL_TRGEN = 8;
  // Channel register fields
  localparam int TOCP_CH_DIR_LSB = 0;
  localparam int TOCP_CH_FAST = 2;
  localparam int TOCP_CH_PRE = 3;
  localparam int TOCP_CH_FUNC_LSB = 4;
  localparam int TOCP_CH_POL = 8;
  localparam int TOCP_CH_OEN = 9;
  localparam int TOCP_CH_IE = 10;
  localparam int TOCP_CH_DE = 11;
  // Event and status fields
  localparam int TOCP_EVT_UPD = 0;
  localparam int TOCP_STS_MATCH = 0;
  localparam int TOCP_STS_REF = 1;
  localparam int TOCP_STS_PIN = 2;
  // Codes and reset values
  localparam logic [1:0] TOCP_DIR_OUT = 2'h0;
  localparam logic [15:0] TOCP_RST_RELOAD = 16'hFFFF;
  localparam logic [15:0] TOCP_RST_ZERO = 16'h0000;
  typedef enum logic [2:0] {
    TOCP_F_FROZEN = 3'b000,
    TOCP_F_ACTIVE = 3'b001,
    TOCP_F_INACT = 3'b010,
    TOCP_F_TOGGLE = 3'b011,
    TOCP_F_FORCE_LO = 3'b100,
    TOCP_F_FORCE_HI = 3'b101,
    TOCP_F_PWM1 = 3'b110,
    TOCP_F_PWM2 = 3'b111
  } tocp_func_e;
endpackage : tocp_pkg

// ===== logic/tocp_shadow.sv
// Preload register with shadow copy loaded on update
`timescale 1ns/1ps
module tocp_shadow
  import tocp_pkg::*;
#(
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Software side
  input wire logic wr,
  input wire logic [15:0] wdata,
  input wire logic buffered,
  input wire logic update,
  // Values
  output logic [15:0] preload,
  output logic [15:0] shadow
);
  // Preload register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      preload <= RST_VAL;
    end else if (wr) begin
      preload <= wdata;
    end
  end

  // Shadow copy: direct when unbuffered, else at update
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      shadow <= RST_VAL;
    end else if (!buffered && wr) begin
      shadow <= wdata;
    end else if (update) begin
      shadow <= preload;
    end
  end
endmodule : tocp_shadow

// ===== logic/tocp_top.sv
// Timer channel output compare and PWM stage with register port
`timescale 1ns/1ps
module tocp_top
  import tocp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [15:0] reg_rdata,
  // Trigger from slave-mode logic
  input wire logic trigger_input,
  // Channel outputs
  output logic compare_output_pin,
  output logic compare_output_pin_oe,
  output logic irq_req,
  output logic dma_req
);

  ////////////////////////////////////////////////////////////////////////
  // Control state
  logic counter_run;
  logic single_pulse_select;
  logic reload_preload_enable;
  logic trigger_enable;
  logic [1:0] channel_direction_select;
  logic fast_output_enable;
  logic compare_preload_enable;
  logic [2:0] compare_output_function;
  logic channel_polarity;
  logic channel_output_enable;
  logic channel_irq_enable;
  logic channel_dma_enable;
  logic channel_match_flag;
  logic compare_reference_wave;
  logic [15:0] counter_value;
  logic [15:0] reload_pre;
  logic [15:0] auto_reload_value;
  logic [15:0] cmp_pre;
  logic [15:0] compare_value;
  logic update_event;
  logic roll_over;
  logic sw_update;
  logic match;
  logic is_output;
  logic is_pwm;
  logic trig_start;
  logic fast_kick;
  logic fast_hold;
  logic next_ref;
  logic wr_ctrl;
  logic wr_chan;

  assign wr_ctrl = reg_wr && (reg_addr == TOCP_REG_CTRL);
  assign wr_chan = reg_wr && (reg_addr == TOCP_REG_CHAN);
  assign sw_update = reg_wr && (reg_addr == TOCP_REG_EVT)
                     && reg_wdata[TOCP_EVT_UPD];
  assign is_output = (channel_direction_select == TOCP_DIR_OUT);
  assign is_pwm = compare_output_function[2]
                  && compare_output_function[1];
  // Trigger start: slave trigger mode while stopped
  assign trig_start = trigger_enable && trigger_input
                      && !counter_run;
  assign fast_kick = trig_start && fast_output_enable && is_pwm;
  // Counter rolls from reload to zero while running
  assign roll_over = counter_run
                     && (counter_value == auto_reload_value);
  assign update_event = roll_over || sw_update;
  // Match against shadow compare on every clock
  assign match = (counter_value == compare_value);

  ////////////////////////////////////////////////////////////////////////
  // Shadow registers for reload and compare
  tocp_shadow #(
    .RST_VAL(TOCP_RST_RELOAD)
  ) u_reload (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr(reg_wr && (reg_addr == TOCP_REG_RELOAD)),
    .wdata(reg_wdata),
    .buffered(reload_preload_enable),
    .update(update_event),
    .preload(reload_pre),
    .shadow(auto_reload_value)
  );

  tocp_shadow #(
    .RST_VAL(TOCP_RST_ZERO)
  ) u_compare (
    .sys_clk(sys_clk),
    .rst(rst),
    .wr(reg_wr && (reg_addr == TOCP_REG_CMP)),
    .wdata(reg_wdata),
    .buffered(compare_preload_enable),
    .update(update_event),
    .preload(cmp_pre),
    .shadow(compare_value)
  );

  ////////////////////////////////////////////////////////////////////////
  // Timer control register and run bit
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_run <= 1'b0;
      single_pulse_select <= 1'b0;
      reload_preload_enable <= 1'b0;
      trigger_enable <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        single_pulse_select <= reg_wdata[TOCP_CTRL_SINGLE];
        reload_preload_enable <= reg_wdata[TOCP_CTRL_ARPRE];
        trigger_enable <= reg_wdata[TOCP_CTRL_TRGEN];
      end
      if (roll_over && single_pulse_select) begin
        counter_run <= 1'b0;
      end else if (wr_ctrl) begin
        counter_run <= reg_wdata[TOCP_CTRL_RUN];
      end else if (trig_start) begin
        counter_run <= 1'b1;
      end
    end
  end

  // Up counter; edge-aligned, counts upward only
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      counter_value <= TOCP_RST_ZERO;
    end else if (reg_wr && (reg_addr == TOCP_REG_CNT)) begin
      counter_value <= reg_wdata;
    end else if (sw_update || roll_over) begin
      counter_value <= TOCP_RST_ZERO;
    end else if (counter_run) begin
      counter_value <= counter_value + 16'h0001;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Channel configuration register
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_direction_select <= TOCP_DIR_OUT;
      fast_output_enable <= 1'b0;
      compare_preload_enable <= 1'b0;
      compare_output_function <= TOCP_F_FROZEN;
      channel_polarity <= 1'b0;
      channel_output_enable <= 1'b0;
      channel_irq_enable <= 1'b0;
      channel_dma_enable <= 1'b0;
    end else if (wr_chan) begin
      channel_direction_select <= reg_wdata[TOCP_CH_DIR_LSB +: 2];
      fast_output_enable <= reg_wdata[TOCP_CH_FAST];
      compare_preload_enable <= reg_wdata[TOCP_CH_PRE];
      compare_output_function <= reg_wdata[TOCP_CH_FUNC_LSB +: 3];
      channel_polarity <= reg_wdata[TOCP_CH_POL];
      channel_output_enable <= reg_wdata[TOCP_CH_OEN];
      channel_irq_enable <= reg_wdata[TOCP_CH_IE];
      channel_dma_enable <= reg_wdata[TOCP_CH_DE];
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Next reference level by output function
  always_comb begin
    next_ref = compare_reference_wave;
    case (compare_output_function)
      TOCP_F_FROZEN: begin
        next_ref = compare_reference_wave;
      end
      TOCP_F_ACTIVE: begin
        if (match) begin
          next_ref = 1'b1;
        end
      end
      TOCP_F_INACT: begin
        if (match) begin
          next_ref = 1'b0;
        end
      end
      TOCP_F_TOGGLE: begin
        if (match) begin
          next_ref = !compare_reference_wave;
        end
      end
      TOCP_F_FORCE_LO: begin
        next_ref = 1'b0;
      end
      TOCP_F_FORCE_HI: begin
        next_ref = 1'b1;
      end
      TOCP_F_PWM1: begin
        // Zero compare holds low, above reload holds high
        next_ref = (counter_value < compare_value);
      end
      TOCP_F_PWM2: begin
        next_ref = !(counter_value < compare_value);
      end
      default: begin
        next_ref = compare_reference_wave;
      end
    endcase
    // Fast path: matched level from trigger until the real match
    if (fast_kick || (fast_hold && is_pwm)) begin
      next_ref = (compare_output_function == TOCP_F_PWM2);
    end
    if (!is_output) begin
      next_ref = compare_reference_wave;
    end
  end

  // Reference wave; update event has no direct effect here
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compare_reference_wave <= 1'b0;
    end else begin
      compare_reference_wave <= next_ref;
    end
  end

  // Fast hold: keeps matched level until the compare catches up
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      fast_hold <= 1'b0;
    end else if (fast_kick) begin
      fast_hold <= 1'b1;
    end else if (match || update_event || !is_pwm) begin
      fast_hold <= 1'b0;
    end
  end

  // Output pin with polarity and enable
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      compare_output_pin <= 1'b0;
      compare_output_pin_oe <= 1'b0;
    end else begin
      compare_output_pin <= next_ref ^ channel_polarity;
      compare_output_pin_oe <= channel_output_enable && is_output;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Match flag: set wins over software clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      channel_match_flag <= 1'b0;
    end else if (match && is_output) begin
      channel_match_flag <= 1'b1;
    end else if (reg_wr && (reg_addr == TOCP_REG_STS)
                 && !reg_wdata[TOCP_STS_MATCH]) begin
      channel_match_flag <= 1'b0;
    end
  end

  // Interrupt level and DMA request on every cycle of match
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_req <= 1'b0;
      dma_req <= 1'b0;
    end else begin
      irq_req <= channel_irq_enable
                 && (channel_match_flag || (match && is_output));
      dma_req <= channel_dma_enable && match && is_output;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Read data, one cycle after the read strobe
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 16'h0000;
    end else if (reg_rd) begin
      case (reg_addr)
        TOCP_REG_CTRL: begin
          reg_rdata <= {7'h00, trigger_enable, reload_preload_enable,
                        3'h0, single_pulse_select, 2'h0, counter_run};
        end
        TOCP_REG_CHAN: begin
          reg_rdata <= {4'h0, channel_dma_enable, channel_irq_enable,
                        channel_output_enable, channel_polarity, 1'b0,
                        compare_output_function, compare_preload_enable,
                        fast_output_enable, channel_direction_select};
        end
        TOCP_REG_STS: begin
          reg_rdata <= {13'h0000, compare_output_pin,
                        compare_reference_wave, channel_match_flag};
        end
        TOCP_REG_CNT: begin
          reg_rdata <= counter_value;
        end
        TOCP_REG_RELOAD: begin
          reg_rdata <= reload_pre;
        end
        TOCP_REG_CMP: begin
          reg_rdata <= cmp_pre;
        end
        default: begin
          reg_rdata <= 16'h0000;
        end
      endcase
    end else begin
      reg_rdata <= 16'h0000;
    end
  end
endmodule : tocp_top

// ===== tb/tocp_bench.sv
// Self-checking bench of the timer compare output stage
`timescale 1ns/1ps
module tocp_bench
  import tocp_pkg::*;
();
  logic sys_clk, rst, reg_wr, reg_rd, trigger_input, pin, oe, irq, dma;
  logic [3:0] reg_addr;
  logic [15:0] reg_wdata, reg_rdata, rv, e;
  int error_cnt, n_compared, cyc, hi, dmas;
  logic [2:0] pf [4] = '{3'h6, 3'h7, 3'h6, 3'h6};
  logic [15:0] pc [4] = '{16'h0004, 16'h0004, 16'h0000, 16'h000C};
  logic [15:0] pe [4] = '{16'h0008, 16'h000C, 16'h0000, 16'h0014};
  logic [3:0] lvl = 4'h5;
  logic [3:0] oc = 4'hB;
  tocp_top i_tocp_top (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_input(trigger_input),
    .compare_output_pin(pin), .compare_output_pin_oe(oe), .irq_req(irq),
    .dma_req(dma));
  ////////////////////////////////////////////////////////////////////////////
  // Clock of 40 ns
  initial begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end
  // Match pulse counter and hang guard
  always @(posedge sys_clk) begin
    cyc++;
    if (dma === 1'b1) dmas++;
    if (cyc == 6000) begin
      error_cnt++;
      finish_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      error_cnt++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask : rd
  // Channel word from enables, function and preload/fast bits
  function automatic logic [15:0] chw(input logic [3:0] en,
    input logic [2:0] f, input logic [1:0] pf2);
    return {4'h0, en, 1'b0, f, pf2, 2'h0};
  endfunction : chw
  task automatic run(input int n);
    wr(TOCP_REG_CNT, 16'h0000);
    wr(TOCP_REG_CTRL, 16'h0001);
    repeat (n) @(posedge sys_clk);
    wr(TOCP_REG_CTRL, 16'h0000);
  endtask : run
  task automatic hcount(input int n);
    hi = 0;
    repeat (n) begin
      @(posedge sys_clk);
      #1 hi += int'(pin);
    end
  endtask : hcount
  task automatic finish_test();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : finish_test
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    rst = 1'b1;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    trigger_input = 1'b0;
    repeat (3) @(posedge sys_clk);
    rst <= 1'b0;
    // Reset values and an unmapped index
    rd(TOCP_REG_RELOAD);
    chk("reload", rv, TOCP_RST_RELOAD);
    rd(4'hC);
    chk("unmapped", rv, 16'h0000);
    $display("reset test done");
    // Forced levels on both polarities, then matches while forced
    wr(TOCP_REG_RELOAD, 16'h0014);
    wr(TOCP_REG_CMP, 16'h0005);
    for (int k = 0; k < 4; k++) begin
      wr(TOCP_REG_CHAN, chw({3'h1, k[0]}, {2'h2, k[1]}, 2'h0));
      repeat (3) @(posedge sys_clk);
      chk("forced pin", 16'(pin), 16'(k[1] ^ k[0]));
      chk("pin enable", 16'(oe), 16'h0001);
    end
    // Input direction keeps the pin undriven
    wr(TOCP_REG_CHAN, chw(4'h2, 3'h5, 2'h0) | 16'h0001);
    repeat (3) @(posedge sys_clk);
    chk("input pin enable", 16'(oe), 16'h0000);
    wr(TOCP_REG_CHAN, chw(4'hE, 3'h5, 2'h0));
    run(10);
    rd(TOCP_REG_STS);
    chk("forced status", rv & 16'h0007, 16'h0007);
    chk("forced irq", 16'(irq), 16'h0001);
    wr(TOCP_REG_STS, 16'h0000);
    repeat (3) @(posedge sys_clk);
    chk("irq cleared", 16'(irq), 16'h0000);
    $display("forced test done");
    // Match actions from a known start level, update leaves them
    dmas = 0;
    for (int k = 0; k < 4; k++) begin
      e = {13'h0, oc[k], oc[k], 1'b1};
      wr(TOCP_REG_CHAN, chw(4'h2, {2'h2, lvl[k]}, 2'h0));
      repeat (2) @(posedge sys_clk);
      wr(TOCP_REG_CHAN, chw(4'hA, 3'(k), 2'h0));
      run(10);
      rd(TOCP_REG_STS);
      chk("match action", rv & 16'h0007, e);
      wr(TOCP_REG_EVT, 16'h0001);
      rd(TOCP_REG_STS);
      chk("update keeps ref", rv & 16'h0006, e & 16'h0006);
      wr(TOCP_REG_STS, 16'h0000);
    end
    chk("match dma", 16'(dmas), 16'h0004);
    $display("compare test done");
    // Compare preload holds the new value until an update
    wr(TOCP_REG_CMP, 16'h000C);
    wr(TOCP_REG_CHAN, chw(4'h2, 3'h0, 2'h2));
    wr(TOCP_REG_CMP, 16'h0003);
    run(6);
    rd(TOCP_REG_STS);
    chk("flag before update", rv & 16'h0001, 16'h0000);
    wr(TOCP_REG_EVT, 16'h0001);
    run(6);
    rd(TOCP_REG_STS);
    chk("flag after update", rv & 16'h0001, 16'h0001);
    $display("preload test done");
    // Edge-aligned waveforms over two whole periods
    wr(TOCP_REG_RELOAD, 16'h0009);
    for (int k = 0; k < 4; k++) begin
      wr(TOCP_REG_CHAN, chw(4'h2, pf[k], 2'h2));
      wr(TOCP_REG_CMP, pc[k]);
      wr(TOCP_REG_EVT, 16'h0001);
      wr(TOCP_REG_CTRL, 16'h0081);
      repeat (12) @(posedge sys_clk);
      hcount(20);
      chk("pwm highs", 16'(hi), pe[k]);
    end
    $display("pwm test done");
    // One pulse from a trigger, then continuous counting again
    wr(TOCP_REG_CTRL, 16'h0000);
    wr(TOCP_REG_CHAN, chw(4'h2, 3'h7, 2'h2));
    wr(TOCP_REG_CMP, 16'h0003);
    wr(TOCP_REG_EVT, 16'h0001);
    wr(TOCP_REG_CTRL, 16'h0188);
    @(posedge sys_clk);
    trigger_input <= 1'b1;
    @(posedge sys_clk);
    trigger_input <= 1'b0;
    #1 chk("slow start", 16'(pin), 16'h0000);
    hcount(30);
    chk("pulse length", 16'(hi > 5 && hi < 8), 16'h0001);
    rd(TOCP_REG_CTRL);
    chk("run after pulse", rv & 16'h0001, 16'h0000);
    wr(TOCP_REG_CTRL, 16'h0081);
    repeat (30) @(posedge sys_clk);
    rd(TOCP_REG_CTRL);
    chk("run continuous", rv & 16'h0001, 16'h0001);
    // Fast enable: pulse starts at the trigger itself
    wr(TOCP_REG_CTRL, 16'h0000);
    wr(TOCP_REG_CHAN, chw(4'h2, 3'h7, 2'h3));
    wr(TOCP_REG_EVT, 16'h0001);
    wr(TOCP_REG_CTRL, 16'h0188);
    @(posedge sys_clk);
    trigger_input <= 1'b1;
    @(posedge sys_clk);
    trigger_input <= 1'b0;
    #1 chk("fast start", 16'(pin), 16'h0001);
    hcount(30);
    // No delay left: high over the whole count, zero to reload 9
    chk("fast length", 16'(hi), 16'h000A);
    $display("pulse test done");
    finish_test();
  end
endmodule : tocp_bench

// ===== tb/tocp_chk.sv
// Port checker of the timer compare output stage
`timescale 1ns/1ps
module tocp_chk
  import tocp_pkg::*;
(
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst,
  // Register port
  input wire logic [3:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  // Channel side
  input wire logic trigger_input,
  input wire logic compare_output_pin,
  input wire logic compare_output_pin_oe,
  input wire logic irq_req,
  input wire logic dma_req
);
  logic [15:0] ch;
  logic [1:0] age;
  logic calm;
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);
  ////////////////////////////////////////////////////////////////////////////
  // Channel word copy and cycles since it changed
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      ch <= 16'h0000;
      age <= 2'h0;
    end else if (reg_wr && reg_addr == TOCP_REG_CHAN) begin
      ch <= reg_wdata;
      age <= 2'h0;
    end else if (age != 2'h3) begin
      age <= age + 2'h1;
    end
  end
  // Output channel settled for three cycles
  assign calm = age == 2'h3 && ch[1:0] == TOCP_DIR_OUT;
  ////////////////////////////////////////////////////////////////////////////
  a_reset_quiet:
    assert property ($past(rst) |-> !compare_output_pin
      && !compare_output_pin_oe && !irq_req && !dma_req)
    else $error("output active after reset");
  a_read_idle:
    assert property (!$past(reg_rd) |-> reg_rdata == 16'h0000)
    else $error("read data outside read cycle");
  a_enable_rise:
    assert property ($rose(compare_output_pin_oe) |-> ch[9]
      && ch[1:0] == TOCP_DIR_OUT) else $error("pin enabled while off");
  a_force_high:
    assert property (calm && ch[6:4] == 3'h5 |->
      compare_output_pin == !ch[8]) else $error("forced high wrong");
  a_force_low:
    assert property (calm && ch[6:4] == 3'h4 |->
      compare_output_pin == ch[8]) else $error("forced low wrong");
  a_irq_gate:
    assert property (age == 2'h3 && irq_req |-> calm && ch[10])
    else $error("irq without enable");
  a_dma_gate:
    assert property (age == 2'h3 && dma_req |-> calm && ch[11])
    else $error("dma without enable");
  a_irq_hold:
    assert property ($past(irq_req) && calm && !$past(reg_wr)
      && !$past(reg_wr, 2) |-> irq_req) else $error("irq dropped");
endmodule : tocp_chk

bind tocp_top tocp_chk i_tocp_chk (.sys_clk(sys_clk), .rst(rst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_rdata(reg_rdata), .trigger_input(trigger_input),
  .compare_output_pin(compare_output_pin),
  .compare_output_pin_oe(compare_output_pin_oe), .irq_req(irq_req),
  .dma_req(dma_req));
